//--- hdl/ceel_pkg.sv
// constants, codes and helpers of the communication error event log
`default_nettype none
package ceel_pkg;

  // holding register addresses of the log, as seen on the register map
  localparam logic [15:0] ADDR_SOURCE = 16'h9cec;
  localparam logic [15:0] ADDR_COMMAND = 16'h9ced;
  localparam logic [15:0] ADDR_REQUEST = 16'h9cee;
  localparam logic [15:0] ADDR_CAUSE = 16'h9cef;
  localparam logic [15:0] ADDR_MASK1_HI = 16'h9cf0;
  localparam logic [15:0] ADDR_MASK1_LO = 16'h9cf1;
  localparam logic [15:0] ADDR_MASK2_HI = 16'h9cf2;
  localparam logic [15:0] ADDR_MASK2_LO = 16'h9cf3;

  // word count and word positions inside the record
  localparam int LOG_WORDS = 8;
  localparam logic [2:0] IDX_SOURCE = 3'h0;
  localparam logic [2:0] IDX_COMMAND = 3'h1;
  localparam logic [2:0] IDX_REQUEST = 3'h2;
  localparam logic [2:0] IDX_CAUSE = 3'h3;
  localparam logic [2:0] IDX_MASK1_HI = 3'h4;
  localparam logic [2:0] IDX_MASK1_LO = 3'h5;
  localparam logic [2:0] IDX_MASK2_HI = 3'h6;
  localparam logic [2:0] IDX_MASK2_LO = 3'h7;

  // reset value of every log word
  localparam logic [15:0] LOG_RESET = 16'h0000;

  // port on which the error arose
  typedef enum logic [1:0] {
    CEEL_PORT_TOKEN_BUS = 2'b00,
    CEEL_PORT_NETWORK = 2'b01,
    CEEL_PORT_RS232 = 2'b10,
    CEEL_PORT_RS485 = 2'b11
  } ceel_port_e;

  // cause codes, device level then protocol level
  localparam logic [15:0] CAUSE_BAD_PASSWORD = 16'h0001;
  localparam logic [15:0] CAUSE_CHECKSUM = 16'h0002;
  localparam logic [15:0] CAUSE_RANGE = 16'h0003;
  localparam logic [15:0] CAUSE_BAD_BLOCK = 16'h0004;
  localparam logic [15:0] CAUSE_DATA_RANGE = 16'h0005;
  localparam logic [15:0] CAUSE_BAD_DATA = 16'h0006;
  localparam logic [15:0] CAUSE_LOCKED = 16'h0007;
  localparam logic [15:0] CAUSE_CROSS_GROUP = 16'h0008;
  localparam logic [15:0] CAUSE_BREAKER = 16'h0009;
  localparam logic [15:0] CAUSE_BELOW_MIN = 16'h000a;
  localparam logic [15:0] CAUSE_ABOVE_MAX = 16'h000b;
  localparam logic [15:0] CAUSE_OUT_OF_STEP = 16'h000c;
  localparam logic [15:0] CAUSE_BAD_REFERENCE = 16'h0020;
  localparam logic [15:0] CAUSE_TOO_MANY_REGS = 16'h0021;
  localparam logic [15:0] CAUSE_BAD_FUNCTION = 16'h0022;
  localparam logic [15:0] CAUSE_BAD_RECORD = 16'h0023;

  // true when a register address falls inside the log window
  function automatic logic ceel_in_log(input logic [15:0] addr);
    return (addr >= ADDR_SOURCE) && (addr <= ADDR_MASK2_LO);
  endfunction

  // true for every cause code that the log defines
  function automatic logic ceel_cause_ok(input logic [15:0] cause);
    return ((cause >= CAUSE_BAD_PASSWORD) && (cause <= CAUSE_OUT_OF_STEP))
      || ((cause >= CAUSE_BAD_REFERENCE) && (cause <= CAUSE_BAD_RECORD));
  endfunction

  // command word: function code alone, or command over subcommand
  function automatic logic [15:0] ceel_cmd_word(input logic modbus,
      input logic [7:0] func, input logic [7:0] cmd,
      input logic [7:0] sub);
    return modbus ? {8'h00, func} : {cmd, sub};
  endfunction

endpackage
`default_nettype wire

//--- hdl/ceel_rec_if.sv
// record carrier between the log front end and the word store
`default_nettype none
interface ceel_rec_if;
  logic wr;
  logic [15:0] wr_word [ceel_pkg::LOG_WORDS];
  logic [15:0] log_word [ceel_pkg::LOG_WORDS];

  modport writer (output wr, output wr_word, input log_word);
  modport store (input wr, input wr_word, output log_word);
endinterface
`default_nettype wire

//--- hdl/ceel_store.sv
// eight word store that holds the most recent error record
`default_nettype none
module ceel_store (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // record carrier
  ceel_rec_if.store rec
);

  logic [15:0] word_reg [ceel_pkg::LOG_WORDS];

  // all words load together so a reader never sees a mixed record
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < ceel_pkg::LOG_WORDS; i++) begin
        word_reg[i] <= ceel_pkg::LOG_RESET;
      end
    end else if (rec.wr) begin
      for (int i = 0; i < ceel_pkg::LOG_WORDS; i++) begin
        word_reg[i] <= rec.wr_word[i];
      end
    end
  end

  // reads look straight at the store and never disturb it
  assign rec.log_word = word_reg;

endmodule
`default_nettype wire

//--- hdl/ceel_top.sv
// communication error event log: record capture, exception and readback
`default_nettype none

// Function
// - a rejected command is answered with an exception, not a normal reply
// - eight registers hold only the latest error, from any port
// - source word: 0 token bus, 1 network, 2 RS232, 3 RS485
// - command word: function code, or command high and subcommand low
// - request word holds the register address of the failed request
// - cause codes 1 to 12 name device level faults
// - cause codes 32 to 35 name protocol level faults
// - control write masks stored high word first, then low word
module ceel_top (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // rejected command report from the protocol engines
  input wire logic i_err_valid,
  input wire logic [1:0] i_err_port,
  input wire logic i_err_modbus,
  input wire logic [7:0] i_err_func,
  input wire logic [7:0] i_err_cmd,
  input wire logic [7:0] i_err_subcmd,
  input wire logic [15:0] i_err_addr,
  input wire logic [15:0] i_err_cause,
  input wire logic i_err_ctrl_write,
  input wire logic [31:0] i_err_mask1,
  input wire logic [31:0] i_err_mask2,
  // exception answer towards the requester
  output logic o_exc_valid,
  output logic [1:0] o_exc_port,
  output logic [15:0] o_exc_cause,
  // holding register read port
  input wire logic i_rd_req,
  input wire logic [15:0] i_rd_addr,
  output logic o_rd_valid,
  output logic o_rd_hit,
  output logic [15:0] o_rd_data
);

  ceel_rec_if rec ();

  // the read index is three bits wide, so the record must be eight words;
  // a longer record would need a wider index and a longer address window
  if (ceel_pkg::LOG_WORDS != 8) begin : g_words_check
    $error("record must hold eight words");
  end

  logic exc_valid_reg;
  logic [1:0] exc_port_reg;
  logic [15:0] exc_cause_reg;
  logic rd_valid_reg;
  logic rd_hit_reg;
  logic [15:0] rd_data_reg;

  wire logic [15:0] mask1_hi_w;
  wire logic [15:0] mask1_lo_w;
  wire logic [15:0] mask2_hi_w;
  wire logic [15:0] mask2_lo_w;
  wire logic rd_hit_w;
  wire logic [15:0] rd_off_w;
  wire logic [2:0] rd_idx_w;
  wire logic [15:0] rd_word_w;

  ceel_store u_store (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .rec(rec.store)
  );

  // masks are only meaningful for control writes; others log zero so a
  // stale mask of an earlier error cannot be mistaken for this one
  assign mask1_hi_w = i_err_ctrl_write ? i_err_mask1[31:16] : 16'h0000;
  assign mask1_lo_w = i_err_ctrl_write ? i_err_mask1[15:0] : 16'h0000;
  assign mask2_hi_w = i_err_ctrl_write ? i_err_mask2[31:16] : 16'h0000;
  assign mask2_lo_w = i_err_ctrl_write ? i_err_mask2[15:0] : 16'h0000;

  // record assembly: every word is rewritten on each error
  assign rec.wr = i_err_valid;
  assign rec.wr_word[ceel_pkg::IDX_SOURCE] = {14'h0000, i_err_port};
  assign rec.wr_word[ceel_pkg::IDX_COMMAND] = ceel_pkg::ceel_cmd_word(
    i_err_modbus, i_err_func, i_err_cmd, i_err_subcmd);
  assign rec.wr_word[ceel_pkg::IDX_REQUEST] = i_err_addr;
  // cause is logged as reported; both code families pass through
  assign rec.wr_word[ceel_pkg::IDX_CAUSE] = i_err_cause;
  assign rec.wr_word[ceel_pkg::IDX_MASK1_HI] = mask1_hi_w;
  assign rec.wr_word[ceel_pkg::IDX_MASK1_LO] = mask1_lo_w;
  assign rec.wr_word[ceel_pkg::IDX_MASK2_HI] = mask2_hi_w;
  assign rec.wr_word[ceel_pkg::IDX_MASK2_LO] = mask2_lo_w;

  // exception answer, one cycle after the rejected command
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      exc_valid_reg <= 1'b0;
      exc_port_reg <= 2'b00;
      exc_cause_reg <= 16'h0000;
    end else begin
      exc_valid_reg <= i_err_valid;
      if (i_err_valid) begin
        exc_port_reg <= i_err_port;
        exc_cause_reg <= i_err_cause;
      end
    end
  end

  // read decode; the record is only looked at, never cleared
  assign rd_hit_w = ceel_pkg::ceel_in_log(i_rd_addr);
  assign rd_off_w = i_rd_addr - ceel_pkg::ADDR_SOURCE;
  assign rd_idx_w = rd_off_w[2:0];
  assign rd_word_w = rd_hit_w ? rec.log_word[rd_idx_w] : 16'h0000;

  // read answer; a read in the cycle of an error still sees the old record
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_valid_reg <= 1'b0;
      rd_hit_reg <= 1'b0;
      rd_data_reg <= 16'h0000;
    end else begin
      rd_valid_reg <= i_rd_req;
      rd_hit_reg <= i_rd_req && rd_hit_w;
      if (i_rd_req) begin
        rd_data_reg <= rd_word_w;
      end
    end
  end

  assign o_exc_valid = exc_valid_reg;
  assign o_exc_port = exc_port_reg;
  assign o_exc_cause = exc_cause_reg;
  assign o_rd_valid = rd_valid_reg;
  assign o_rd_hit = rd_hit_reg;
  assign o_rd_data = rd_data_reg;

  // checks on the design's own outputs and record
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  // exception answer: one pulse with the reported port and cause
  exc_answer_a: assert property (
    i_err_valid |=> o_exc_valid && (o_exc_cause == $past(i_err_cause))
      && (o_exc_port == $past(i_err_port)))
    else $error("exception answer missing or wrong");

  exc_quiet_a: assert property (
    !i_err_valid |=> !o_exc_valid)
    else $error("exception answer without an error");

  // record load: each word follows its report field one edge later
  source_word_a: assert property (
    i_err_valid |=> rec.log_word[ceel_pkg::IDX_SOURCE]
      == {14'h0000, $past(i_err_port)})
    else $error("source word does not match the failing port");

  cmd_modbus_a: assert property (
    i_err_valid && i_err_modbus |=>
      rec.log_word[ceel_pkg::IDX_COMMAND] == {8'h00, $past(i_err_func)})
    else $error("function code not logged");

  cmd_split_a: assert property (
    i_err_valid && !i_err_modbus |=>
      rec.log_word[ceel_pkg::IDX_COMMAND]
        == {$past(i_err_cmd), $past(i_err_subcmd)})
    else $error("command and subcommand not logged in byte order");

  req_addr_a: assert property (
    i_err_valid |=> rec.log_word[ceel_pkg::IDX_REQUEST] == $past(i_err_addr))
    else $error("requested address not logged");

  cause_code_a: assert property (
    i_err_valid && ceel_pkg::ceel_cause_ok(i_err_cause) |=>
      ceel_pkg::ceel_cause_ok(rec.log_word[ceel_pkg::IDX_CAUSE])
      && (rec.log_word[ceel_pkg::IDX_CAUSE] == $past(i_err_cause)))
    else $error("cause code not logged");

  proto_cause_a: assert property (
    i_err_valid && (i_err_cause >= ceel_pkg::CAUSE_BAD_REFERENCE) |=>
      rec.log_word[ceel_pkg::IDX_CAUSE] >= ceel_pkg::CAUSE_BAD_REFERENCE)
    else $error("protocol level cause lost");

  mask_order_a: assert property (
    i_err_valid && i_err_ctrl_write |=>
      ({rec.log_word[ceel_pkg::IDX_MASK1_HI],
        rec.log_word[ceel_pkg::IDX_MASK1_LO]} == $past(i_err_mask1))
      && ({rec.log_word[ceel_pkg::IDX_MASK2_HI],
        rec.log_word[ceel_pkg::IDX_MASK2_LO]} == $past(i_err_mask2)))
    else $error("control masks not logged high word first");

  // record hold between errors: reads and idle cycles leave every word
  record_hold_a: assert property (
    !i_err_valid |=> $stable(rec.log_word[ceel_pkg::IDX_SOURCE])
      && $stable(rec.log_word[ceel_pkg::IDX_COMMAND])
      && $stable(rec.log_word[ceel_pkg::IDX_REQUEST])
      && $stable(rec.log_word[ceel_pkg::IDX_CAUSE])
      && $stable(rec.log_word[ceel_pkg::IDX_MASK1_HI])
      && $stable(rec.log_word[ceel_pkg::IDX_MASK1_LO])
      && $stable(rec.log_word[ceel_pkg::IDX_MASK2_HI])
      && $stable(rec.log_word[ceel_pkg::IDX_MASK2_LO]))
    else $error("record changed without an error");

  // words that the report does not fill must not keep an older value
  mask_zero_a: assert property (
    i_err_valid && !i_err_ctrl_write |=>
      (rec.log_word[ceel_pkg::IDX_MASK1_HI] == 16'h0000)
      && (rec.log_word[ceel_pkg::IDX_MASK1_LO] == 16'h0000)
      && (rec.log_word[ceel_pkg::IDX_MASK2_HI] == 16'h0000)
      && (rec.log_word[ceel_pkg::IDX_MASK2_LO] == 16'h0000))
    else $error("mask words kept although no control write failed");

  cause_any_a: assert property (
    i_err_valid |=> rec.log_word[ceel_pkg::IDX_CAUSE] == $past(i_err_cause))
    else $error("cause outside the defined codes not logged as given");

  source_clean_a: assert property (
    rec.log_word[ceel_pkg::IDX_SOURCE][15:2] == 14'h0000)
    else $error("source word carries bits above the port number");

  err_chain_a: assert property (
    i_err_valid ##1 i_err_valid |=>
      (rec.log_word[ceel_pkg::IDX_REQUEST] == $past(i_err_addr))
      && (o_exc_cause == $past(i_err_cause)))
    else $error("second of two back to back errors not logged");

  // the exception answer and the record load on the same edge
  exc_hold_a: assert property (
    !i_err_valid |=> $stable(o_exc_port) && $stable(o_exc_cause))
    else $error("exception port or cause moved without an error");

  exc_record_a: assert property (
    (o_exc_port == rec.log_word[ceel_pkg::IDX_SOURCE][1:0])
      && (o_exc_cause == rec.log_word[ceel_pkg::IDX_CAUSE]))
    else $error("exception answer and record disagree");

  exc_family_a: assert property (
    i_err_valid && ceel_pkg::ceel_cause_ok(i_err_cause) |=>
      ceel_pkg::ceel_cause_ok(o_exc_cause))
    else $error("exception cause left the defined code families");

  // check side decode, written out register by register instead of the
  // offset arithmetic of the read path, so a slip there cannot hide
  wire logic chk_in_log_w;
  wire logic [15:0] chk_rd_word_w;

  assign chk_in_log_w = (i_rd_addr >= ceel_pkg::ADDR_SOURCE)
    && (i_rd_addr <= ceel_pkg::ADDR_MASK2_LO);
  assign chk_rd_word_w =
    (i_rd_addr == ceel_pkg::ADDR_SOURCE)
      ? rec.log_word[ceel_pkg::IDX_SOURCE] :
    (i_rd_addr == ceel_pkg::ADDR_COMMAND)
      ? rec.log_word[ceel_pkg::IDX_COMMAND] :
    (i_rd_addr == ceel_pkg::ADDR_REQUEST)
      ? rec.log_word[ceel_pkg::IDX_REQUEST] :
    (i_rd_addr == ceel_pkg::ADDR_CAUSE)
      ? rec.log_word[ceel_pkg::IDX_CAUSE] :
    (i_rd_addr == ceel_pkg::ADDR_MASK1_HI)
      ? rec.log_word[ceel_pkg::IDX_MASK1_HI] :
    (i_rd_addr == ceel_pkg::ADDR_MASK1_LO)
      ? rec.log_word[ceel_pkg::IDX_MASK1_LO] :
    (i_rd_addr == ceel_pkg::ADDR_MASK2_HI)
      ? rec.log_word[ceel_pkg::IDX_MASK2_HI] :
    (i_rd_addr == ceel_pkg::ADDR_MASK2_LO)
      ? rec.log_word[ceel_pkg::IDX_MASK2_LO] : 16'h0000;

  // read path: one answer per request, taken from the record as it stood
  read_back_a: assert property (
    i_rd_req |=> o_rd_valid && (o_rd_hit == $past(chk_in_log_w))
      && (o_rd_data == $past(chk_rd_word_w)))
    else $error("read answer does not match the record");

  read_miss_a: assert property (
    i_rd_req && !chk_in_log_w |=> !o_rd_hit && (o_rd_data == 16'h0000))
    else $error("read outside the log returned data");

  read_pulse_a: assert property (
    !i_rd_req |=> !o_rd_valid && !o_rd_hit)
    else $error("read answer without a read request");

  read_flag_a: assert property (
    o_rd_hit |-> o_rd_valid)
    else $error("hit flag without a read answer");

  hit_decode_a: assert property (
    rd_hit_w == chk_in_log_w)
    else $error("read window decode disagrees with the address map");

  read_hold_a: assert property (
    !i_rd_req |=> $stable(o_rd_data))
    else $error("read data moved without a read request");

  read_old_a: assert property (
    i_rd_req && i_err_valid && (i_rd_addr == ceel_pkg::ADDR_CAUSE) |=>
      o_rd_data == $past(rec.log_word[ceel_pkg::IDX_CAUSE]))
    else $error("read in the cycle of an error saw the new record");

  // main scenarios worth seeing at least once
  err_ctrl_c: cover property (i_err_valid && i_err_ctrl_write);
  err_back_c: cover property (i_err_valid ##1 i_err_valid);
  read_hit_c: cover property (i_rd_req && rd_hit_w ##1 o_rd_hit);
  read_clash_c: cover property (i_rd_req && rd_hit_w && i_err_valid);
  read_miss_c: cover property (i_rd_req && !chk_in_log_w);

endmodule
`default_nettype wire

//--- test/ceel_master.sv
// requester model: reports rejected commands and polls the log
`default_nettype none
module ceel_master (
  // clock
  input wire logic i_ref_clk,
  // rejected command report
  output logic o_err_valid,
  output logic [1:0] o_err_port,
  output logic o_err_modbus,
  output logic [7:0] o_err_func,
  output logic [7:0] o_err_cmd,
  output logic [7:0] o_err_subcmd,
  output logic [15:0] o_err_addr,
  output logic [15:0] o_err_cause,
  output logic o_err_ctrl,
  output logic [63:0] o_err_masks,
  // holding register read
  output logic o_rd_req,
  output logic [15:0] o_rd_addr
);
  timeunit 1ns;
  timeprecision 1ns;

  // quiet lines at time zero
  initial begin
    {o_err_valid, o_err_port, o_err_modbus, o_err_func} = '0;
    {o_err_cmd, o_err_subcmd, o_err_addr, o_err_cause} = '0;
    {o_err_ctrl, o_err_masks, o_rd_req, o_rd_addr} = '0;
  end

  // one report; the unused byte lane carries junk so it must be ignored
  task automatic report(input logic [1:0] p, input logic mb,
      input logic [15:0] cw, input logic [15:0] a, input logic [15:0] c,
      input logic w, input logic [63:0] k);
    o_err_valid = 1'b1;
    o_err_port = p;
    o_err_modbus = mb;
    o_err_func = mb ? cw[7:0] : 8'ha5;
    o_err_cmd = mb ? 8'h5a : cw[15:8];
    o_err_subcmd = mb ? 8'h3c : cw[7:0];
    o_err_addr = a;
    o_err_cause = c;
    o_err_ctrl = w;
    o_err_masks = k;
    @(negedge i_ref_clk);
  endtask

  // one read request, held until the taking edge has passed
  task automatic rd(input logic [15:0] a);
    o_rd_req = 1'b1;
    o_rd_addr = a;
    @(negedge i_ref_clk);
  endtask

  // release: fields flip so a stale value is never mistaken for data;
  // one edge passes so the next request never lands in the same step
  task automatic quiet();
    o_err_valid = 1'b0;
    o_rd_req = 1'b0;
    o_err_port = ~o_err_port;
    o_err_addr = ~o_err_addr;
    o_err_cause = ~o_err_cause;
    o_err_masks = ~o_err_masks;
    o_rd_addr = ~o_rd_addr;
    @(negedge i_ref_clk);
  endtask
endmodule
`default_nettype wire

//--- test/test_ceel_top.sv
// self-checking bench of the communication error event log
`default_nettype none
module test_ceel_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic ev, mb, ctl, rq, exv, rv, hit;
  logic [1:0] pt, xp;
  logic [7:0] fn, cm, sc;
  logic [15:0] ad, ca, ra, xc, rdat;
  logic [63:0] mk;
  logic [15:0] want [8];
  int err_total = 0;
  int comparisons = 0;

  // 20 MHz reference
  always #25 i_ref_clk = ~i_ref_clk;

  ceel_top u_ceel_top (.i_ref_clk, .i_resetn, .i_err_valid(ev),
    .i_err_port(pt), .i_err_modbus(mb), .i_err_func(fn),
    .i_err_cmd(cm), .i_err_subcmd(sc), .i_err_addr(ad),
    .i_err_cause(ca), .i_err_ctrl_write(ctl), .i_err_mask1(mk[63:32]),
    .i_err_mask2(mk[31:0]), .o_exc_valid(exv), .o_exc_port(xp),
    .o_exc_cause(xc), .i_rd_req(rq), .i_rd_addr(ra), .o_rd_valid(rv),
    .o_rd_hit(hit), .o_rd_data(rdat));

  ceel_master u_ceel_master (.i_ref_clk, .o_err_valid(ev),
    .o_err_port(pt), .o_err_modbus(mb), .o_err_func(fn), .o_err_cmd(cm),
    .o_err_subcmd(sc), .o_err_addr(ad), .o_err_cause(ca),
    .o_err_ctrl(ctl), .o_err_masks(mk), .o_rd_req(rq), .o_rd_addr(ra));

  // word compare, flags are passed zero extended
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // verdict and end of run
  task automatic conclude();
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // back to back reads of all eight words against the expected record
  task automatic chk_log();
    for (int i = 0; i < 8; i++) begin
      u_ceel_master.rd(ceel_pkg::ADDR_SOURCE + 16'(i));
      chk({14'h0000, rv, hit}, 16'h0003);
      chk(rdat, want[i]);
    end
    u_ceel_master.quiet();
  endtask

  // one report; expected record worked out from the field rules
  task automatic err(input logic [1:0] p, input logic m,
      input logic [15:0] cw, input logic [15:0] a, input logic [15:0] c,
      input logic w, input logic [63:0] k);
    u_ceel_master.report(p, m, cw, a, c, w, k);
    chk({15'h0000, exv}, 16'h0001);
    chk({14'h0000, xp}, {14'h0000, p});
    chk(xc, c);
    want[0] = {14'h0000, p};
    want[1] = m ? {8'h00, cw[7:0]} : cw;
    want[2] = a;
    want[3] = c;
    want[4] = w ? k[63:48] : 16'h0000;
    want[5] = w ? k[47:32] : 16'h0000;
    want[6] = w ? k[31:16] : 16'h0000;
    want[7] = w ? k[15:0] : 16'h0000;
  endtask

  // main sequence
  initial begin
    logic [15:0] c;
    repeat (3) @(negedge i_ref_clk);
    i_resetn = 1'b1;
    @(negedge i_ref_clk);
    want = '{default: 16'h0000};
    chk_log();
    // addresses just outside the window miss
    u_ceel_master.rd(16'h9ceb);
    chk({14'h0000, rv, hit}, 16'h0002);
    chk(rdat, 16'h0000);
    u_ceel_master.rd(16'h9cf4);
    chk({14'h0000, rv, hit}, 16'h0002);
    chk(rdat, 16'h0000);
    u_ceel_master.quiet();
    // every cause code, ports, protocols and mask use varied alongside
    for (int i = 0; i < 16; i++) begin
      c = (i < 12) ? 16'(i + 1) : 16'(i + 20);
      err(2'(i), i[0], {8'(i + 16), 8'(i + 128)}, 16'(40000 + i), c,
        i[1], {4{16'(i)}} ^ 64'hfedc_ba98_7654_3210);
      u_ceel_master.quiet();
      @(negedge i_ref_clk);
      chk({15'h0000, exv}, 16'h0000);
      chk_log();
      chk_log();
    end
    // back to back errors: the second replaces every word
    err(2'h3, 1'b0, 16'haa55, 16'h9cee, 16'h0022, 1'b1, 64'h1);
    err(2'h0, 1'b1, 16'h0010, 16'h1234, 16'h0005, 1'b0, 64'h2);
    u_ceel_master.quiet();
    chk_log();
    // a read in the cycle of an error still returns the old record
    c = want[3];
    fork
      err(2'h1, 1'b1, 16'h0003, 16'h0001, 16'h0021, 1'b0, 64'h3);
      u_ceel_master.rd(ceel_pkg::ADDR_CAUSE);
    join
    chk(rdat, c);
    u_ceel_master.quiet();
    chk_log();
    // a reset in mid-run clears the answers and the record
    i_resetn = 1'b0;
    @(negedge i_ref_clk);
    chk(xc, 16'h0000);
    chk(rdat, 16'h0000);
    chk({11'h000, rv, hit, exv, xp}, 16'h0000);
    @(negedge i_ref_clk);
    i_resetn = 1'b1;
    @(negedge i_ref_clk);
    want = '{default: 16'h0000};
    chk_log();
    conclude();
  end

  // hang guard, well beyond the few hundred cycles of the sequence
  initial begin
    #100us;
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
